//--- emirq_pkg.sv
// Purpose: Shared constants for the MAC interrupt and PHY management register block.
// Assumes: APB slave, 32-bit data, word-aligned registers.
// Notes:   Offsets other than the pause countdown are placed locally.
`default_nettype none
package emirq_pkg;
    // -------------------------------------------------------------------------
    // Register byte offsets
    // -------------------------------------------------------------------------
    localparam logic [7:0]  OFS_PHY_FRAME   = 8'h34;
    localparam logic [7:0]  OFS_PAUSE       = 8'h38;
    localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h24;
    localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h28;
    localparam logic [7:0]  OFS_IRQ_DISABLE = 8'h2C;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h30;
    // -------------------------------------------------------------------------
    // Interrupt bit positions
    // -------------------------------------------------------------------------
    localparam int BIT_MGMT_DONE   = 0;
    localparam int BIT_RX_DONE     = 1;
    localparam int BIT_RX_USED     = 2;
    localparam int BIT_TX_USED     = 3;
    localparam int BIT_TX_UNDERRUN = 4;
    localparam int BIT_RETRY_LIMIT = 5;
    localparam int BIT_TX_EXHAUST  = 6;
    localparam int BIT_TX_DONE     = 7;
    localparam int BIT_RX_OVERRUN  = 10;
    localparam int BIT_BUS_ERROR   = 11;
    localparam int BIT_PAUSE_SEEN  = 12;
    localparam int BIT_PAUSE_ZERO  = 13;
    localparam int IRQ_W           = 14;
    localparam logic [IRQ_W-1:0] IRQ_IMPL = 14'h3CFF;
    localparam logic [IRQ_W-1:0] MASK_RST = 14'h3FFF;
    // -------------------------------------------------------------------------
    // PHY frame fields
    // -------------------------------------------------------------------------
    localparam int SOF_HI  = 31;
    localparam int SOF_LO  = 30;
    localparam int DIR_HI  = 29;
    localparam int DIR_LO  = 28;
    localparam int PHY_HI  = 27;
    localparam int PHY_LO  = 23;
    localparam int REG_HI  = 22;
    localparam int REG_LO  = 18;
    localparam int TA_HI   = 17;
    localparam int TA_LO   = 16;
    localparam int DATA_HI = 15;
    localparam logic [1:0] DIR_READ  = 2'h2;
    localparam logic [1:0] DIR_WRITE = 2'h1;
    localparam int FRAME_BITS = 32;
    localparam logic [5:0] FRAME_LAST = 6'h1F;
    localparam int PAUSE_W = 16;
    // -------------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------------
    localparam int PAUSE_QUANTUM_BITS = 512;
    localparam logic [6:0] MDC_HALF = 7'h04;
endpackage : emirq_pkg
`default_nettype wire

//--- emirq_regs.sv
// Purpose: Interrupt status/mask logic, PHY management frame shifter, pause countdown.
// Assumes: APB slave with zero wait states; pslverr never raised.
// Notes:   Management pins are plain mdc/mdio with output enable.
// Operation
// R1: Flag 6 on mid-frame buffer exhaustion
// R2: Flag 7 on transmit frame done
// R3: Flag 10 on receive overrun set
// R4: Flag 11 on DMA bus error
// R5: Flag 12 on valid pause frame
// R6: Flag 13 when pause count hits zero
// R7: Enable write unmasks bits
// R8: Disable write masks bits
// R9: Mask register reads masked state
// R10: Data field carries write/read data
// R11: Turnaround field reads as written
// R12: Register address selects PHY register
// R13: Direction 10 read, 01 write
// R14: Software writes start field 01
// R15: Flag 0 when management frame done
// R16: Pause count decrements every 512 bits
// R17: Irq when unmasked flag set
// R18: PHY address selects PHY
// R19: Frame write starts shift, then done
//
// The APB register port is this design's own decision.
`default_nettype none
module emirq_regs
    import emirq_pkg::*;
#(
    parameter int BIT_TIME_CYCLES = 1
) (
    input  wire logic        i_clk,           // System clock
    input  wire logic        i_sys_rst,       // Sync reset, high
    input  wire logic        i_psel,          // APB select
    input  wire logic        i_penable,       // APB enable
    input  wire logic        i_pwrite,        // APB write
    input  wire logic [7:0]  i_paddr,         // APB byte address
    input  wire logic [31:0] i_pwdata,        // APB write data
    output logic      [31:0] o_prdata,        // APB read data
    output logic             o_pready,        // APB ready
    output logic             o_pslverr,       // APB error
    input  wire logic        i_rx_done,       // Event pulses
    input  wire logic        i_rx_used_desc,  // Rx used bit read
    input  wire logic        i_tx_used_desc,  // Tx used bit read
    input  wire logic        i_tx_underrun,   // Tx underrun
    input  wire logic        i_retry_limit,   // Retry limit hit
    input  wire logic        i_tx_exhausted,  // Tx buffers exhausted
    input  wire logic        i_tx_frame_done, // Tx frame done
    input  wire logic        i_rx_overrun,    // Rx overrun status level
    input  wire logic        i_bus_error,     // DMA bus error
    input  wire logic        i_pause_seen,    // Valid pause frame
    input  wire logic        i_pause_load,    // Load pause count
    input  wire logic [15:0] i_pause_value,   // Received pause value
    input  wire logic        i_mdio_in,       // Management data in
    output logic             o_mdc,           // Management clock
    output logic             o_mdio_out,      // Management data out
    output logic             o_mdio_oe,       // Management drive enable
    output logic             o_irq            // Interrupt level
);
    // -------------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------------
    logic             acc;
    logic             wr;
    logic             rd;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
    logic [31:0]      frame;
    logic [PAUSE_W-1:0] pause_count;
    logic             busy;
    logic [31:0]      shreg;
    logic [5:0]       bitcnt;
    logic [6:0]       divcnt;
    logic             mdc_q;
    logic             frame_end;
    logic             is_read;
    logic             ovr_d;
    logic [IRQ_W-1:0] events;
    logic             pause_zero;
    logic [31:0]      next_rdata;
    logic             hit_status;
    logic             hit_enable;
    logic             hit_disable;
    logic             hit_frame;
    logic             hit_pause;
    logic [IRQ_W-1:0] clr_mask;
    logic             frame_start;
    logic             mdc_edge;
    logic             mdc_rise;
    logic             mdc_fall;
    logic             in_data;
    logic             in_release;

    // -------------------------------------------------------------------------
    // Shifter state
    // -------------------------------------------------------------------------
    // One-hot codes; the two illegal codes fall back to idle.
    typedef enum logic [1:0] {
        MG_IDLE  = 2'b01,
        MG_SHIFT = 2'b10
    } emirq_mgmt_state_t;

    emirq_mgmt_state_t mg_state;

    assign acc       = i_psel && i_penable;
    assign wr        = acc && i_pwrite;
    assign rd        = acc && !i_pwrite;
    assign o_pready  = 1'b1;
    assign o_pslverr = 1'b0;

    assign hit_status  = i_paddr == OFS_IRQ_STATUS;
    assign hit_enable  = i_paddr == OFS_IRQ_ENABLE;
    assign hit_disable = i_paddr == OFS_IRQ_DISABLE;
    assign hit_frame   = i_paddr == OFS_PHY_FRAME;
    assign hit_pause   = i_paddr == OFS_PAUSE;

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (i_paddr)
            OFS_IRQ_STATUS: next_rdata[IRQ_W-1:0] = status;
            OFS_IRQ_MASK:   next_rdata[IRQ_W-1:0] = mask;            // [R9]
            OFS_PHY_FRAME:  next_rdata = frame;                      // [R10] [R11]
            OFS_PAUSE:      next_rdata[PAUSE_W-1:0] = pause_count;
            default:        next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            o_prdata <= next_rdata;
        end
    end

    // -------------------------------------------------------------------------
    // Interrupt status and mask
    // -------------------------------------------------------------------------
    // Overrun is a level in the receive status; only its rising edge counts.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ovr_d <= 1'b0;
        end else begin
            ovr_d <= i_rx_overrun;
        end
    end

    always_comb begin
        events = '0;
        events[BIT_MGMT_DONE]   = frame_end;                     // [R15] [R19]
        events[BIT_RX_DONE]     = i_rx_done;
        events[BIT_RX_USED]     = i_rx_used_desc;
        events[BIT_TX_USED]     = i_tx_used_desc;
        events[BIT_TX_UNDERRUN] = i_tx_underrun;
        events[BIT_RETRY_LIMIT] = i_retry_limit;
        events[BIT_TX_EXHAUST]  = i_tx_exhausted;                // [R1]
        events[BIT_TX_DONE]     = i_tx_frame_done;               // [R2]
        events[BIT_RX_OVERRUN]  = i_rx_overrun && !ovr_d;        // [R3]
        events[BIT_BUS_ERROR]   = i_bus_error;                   // [R4]
        events[BIT_PAUSE_SEEN]  = i_pause_seen;                  // [R5]
        events[BIT_PAUSE_ZERO]  = pause_zero;                    // [R6]
    end

    // Read data is taken in the setup cycle, so a read clears only the flags
    // it reported: an event landing in the setup cycle would otherwise be
    // wiped unseen. Set wins over the clear in the same cycle.
    assign clr_mask = (rd && hit_status) ? o_prdata[IRQ_W-1:0] : '0;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            status <= '0;
        end else begin
            status <= (status & ~clr_mask) | events; // [R1] [R2] [R3] [R4] [R5] [R6] [R15]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mask <= MASK_RST;
        end else if (wr && hit_enable) begin
            mask <= mask & ~(i_pwdata[IRQ_W-1:0] & IRQ_IMPL);    // [R7] [R17]
        end else if (wr && hit_disable) begin
            mask <= mask | (i_pwdata[IRQ_W-1:0] & IRQ_IMPL);     // [R8] [R17]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(status & ~mask);                          // [R17]
        end
    end

    // -------------------------------------------------------------------------
    // Pause countdown
    // -------------------------------------------------------------------------
    localparam int QUANTUM_CYCLES = PAUSE_QUANTUM_BITS * BIT_TIME_CYCLES;
    logic [$clog2(QUANTUM_CYCLES+1)-1:0] qcnt;
    logic quantum_tick;
    assign quantum_tick = (qcnt == ($bits(qcnt))'(QUANTUM_CYCLES - 1));

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || pause_count == '0 || quantum_tick) begin
            qcnt <= '0;
        end else begin
            qcnt <= qcnt + 1'b1;                                 // [R16]
        end
    end

    assign pause_zero = quantum_tick && pause_count == PAUSE_W'(1);

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pause_count <= '0;
        end else if (wr && hit_pause) begin
            pause_count <= i_pwdata[PAUSE_W-1:0];
        end else if (i_pause_load) begin
            pause_count <= i_pause_value;
        end else if (quantum_tick && pause_count != '0) begin
            pause_count <= pause_count - 1'b1;                   // [R16] [R6]
        end
    end

    // -------------------------------------------------------------------------
    // Management frame shifter
    // -------------------------------------------------------------------------
    // Frame is shifted MSB first: start, direction, PHY and register
    // address, turnaround, data. A read samples the last 16 bits into data.
    // Start and turnaround go out as written; software keeps them legal.
    assign is_read     = frame[DIR_HI:DIR_LO] == DIR_READ;        // [R13]
    assign busy        = mg_state == MG_SHIFT;
    // A frame write while a frame is on the line is dropped.
    assign frame_start = !busy && wr && hit_frame;                // [R19]
    // One tick per half period of the management clock.
    assign mdc_edge    = busy && divcnt == MDC_HALF;
    assign mdc_rise    = mdc_edge && !mdc_q;
    assign mdc_fall    = mdc_edge && mdc_q;
    assign frame_end   = mdc_fall && bitcnt == FRAME_LAST;        // [R15] [R19]
    // Bit slots are counted from the MSB: data fills the last 16 slots,
    // and the line is freed from the turnaround on.
    assign in_data     = bitcnt >= 6'(FRAME_BITS - 1 - DATA_HI);
    assign in_release  = bitcnt >= 6'(FRAME_BITS - 1 - TA_HI);

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mg_state <= MG_IDLE;
        end else begin
            unique case (mg_state)
                MG_IDLE: begin
                    if (frame_start) begin
                        mg_state <= MG_SHIFT;                     // [R19]
                    end
                end
                MG_SHIFT: begin
                    if (frame_end) begin
                        mg_state <= MG_IDLE;                      // [R19]
                    end
                end
                default: begin
                    mg_state <= MG_IDLE;
                end
            endcase
        end
    end

    // Each half period lasts MDC_HALF+1 cycles; the divider idles at zero.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || frame_start || mdc_edge) begin
            divcnt <= '0;
        end else if (busy) begin
            divcnt <= divcnt + 1'b1;
        end
    end

    // The clock starts low so the first bit is set up a half period early.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || frame_start) begin
            mdc_q <= 1'b0;
        end else if (mdc_edge) begin
            mdc_q <= !mdc_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || frame_start) begin
            bitcnt <= '0;
        end else if (mdc_fall && bitcnt != FRAME_LAST) begin
            bitcnt <= bitcnt + 1'b1;
        end
    end

    // Bits change only on the falling clock so the PHY sees them settled.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            shreg <= '0;
        end else if (frame_start) begin
            shreg <= i_pwdata;                                    // [R12] [R18] [R14]
        end else if (mdc_fall) begin
            shreg <= {shreg[FRAME_BITS-2:0], 1'b0};
        end
    end

    // Read data is sampled on the rising clock, one bit per data slot.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            frame <= 32'h0000_0000;
        end else if (frame_start) begin
            frame <= i_pwdata;                                    // [R10] [R11]
        end else if (is_read && mdc_rise && in_data) begin
            frame[DATA_HI:0] <= {frame[DATA_HI-1:0], i_mdio_in};  // [R10]
        end
    end

    assign o_mdc      = mdc_q;
    assign o_mdio_out = shreg[FRAME_BITS-1];
    // Released during turnaround and data of a read so the PHY can drive.
    assign o_mdio_oe  = busy && !(is_read && in_release);
endmodule : emirq_regs
`default_nettype wire

//--- emirq_regs_props.sv
// Purpose: Port-level checks for the interrupt and PHY management block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound into emirq_regs below the module.
`default_nettype none
module emirq_regs_chk
    import emirq_pkg::*;
(
    input wire logic        i_clk,      // Clock
    input wire logic        i_sys_rst,  // Reset
    input wire logic        i_psel,     // APB select
    input wire logic        i_penable,  // APB enable
    input wire logic        i_pwrite,   // APB write
    input wire logic [7:0]  i_paddr,    // APB address
    input wire logic [31:0] i_pwdata,   // APB write data
    input wire logic [31:0] o_prdata,   // APB read data
    input wire logic        o_mdc,      // Mgmt clock
    input wire logic        o_mdio_out, // Mgmt data out
    input wire logic        o_mdio_oe,  // Mgmt drive enable
    input wire logic        o_irq       // Interrupt
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // ------------------------------------------------------------------
    // Management clock phases and register behaviour
    // ------------------------------------------------------------------
    sequence mdc_high_s; o_mdc [*5] ##1 !o_mdc; endsequence
    sequence mdc_low_s; !o_mdc [*5]; endsequence
    a_irq_reset: assert property (disable iff (1'b0) i_sys_rst |=> !o_irq)
        else $error("irq high after reset");
    a_pins_reset: assert property (disable iff (1'b0) i_sys_rst |=> !o_mdio_oe && !o_mdc)
        else $error("mgmt pins active after reset");
    a_mask_all_quiet: assert property (i_psel && i_penable && i_pwrite && i_paddr == OFS_IRQ_DISABLE
        && i_pwdata[13:0] == 14'h3FFF |=> ##1 !o_irq) else $error("irq while all masked");
    a_rdata_hold: assert property (!(i_psel && !i_penable && !i_pwrite) |=> $stable(o_prdata))
        else $error("read data moved");
    a_mdc_high_run: assert property ($rose(o_mdc) |-> mdc_high_s) else $error("mdc high phase");
    a_mdc_low_run: assert property ($fell(o_mdc) |-> mdc_low_s) else $error("mdc low phase");
    a_data_on_fall: assert property (o_mdc && o_mdio_oe |-> $stable(o_mdio_out))
        else $error("data moved while mdc high");
    a_frame_low_start: assert property ($rose(o_mdio_oe) |-> !o_mdc) else $error("frame began high");
endmodule : emirq_regs_chk
bind emirq_regs emirq_regs_chk u_chk (.i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_mdc, .o_mdio_out, .o_mdio_oe, .o_irq);
`default_nettype wire

//--- emirq_phy_model.sv
// Purpose: Behavioural PHY on the management line.
// Assumes: Frame starts when the block raises its drive enable.
// Notes:   Returns RD on read frames from bit 16 on.
`default_nettype none
module emirq_phy_model #(
    parameter logic [15:0] RD = 16'h0000
) (
    input  wire logic        i_clk,     // Clock
    input  wire logic        i_mdc,     // Mgmt clock
    input  wire logic        i_mdio,    // Data from block
    input  wire logic        i_mdio_oe, // Block drives
    output logic             o_mdio,    // Data to block
    output logic      [31:0] o_rx       // Bits seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       mdc_q = 1'b0, oe_q = 1'b0, tog = 1'b0, bit_q = 1'b0;
    logic [5:0] cnt = 6'h20;
    // ------------------------------------------------------------------
    // Capture and reply
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        mdc_q <= i_mdc;
        oe_q  <= i_mdio_oe;
        tog   <= ~tog;
        if (i_mdio_oe && !oe_q) begin
            cnt  <= '0;
            o_rx <= '0;
        end else if (i_mdc && !mdc_q) begin
            cnt <= cnt + 6'h01;
            if (i_mdio_oe) o_rx <= {o_rx[30:0], i_mdio};
        end
        if (!i_mdc && mdc_q && cnt[5:4] == 2'h1) bit_q <= RD[4'hF - cnt[3:0]];
    end
    // A released line toggles so a stale level can never pass for data
    assign o_mdio = (!i_mdio_oe && cnt[5:4] == 2'h1) ? bit_q : tog;
endmodule : emirq_phy_model
`default_nettype wire

//--- tb.sv
// Purpose: Self-checking bench for emirq_regs.
// Assumes: Zero-wait APB, one cycle per bit time.
// Notes:   Expected values come from the integer model kept here.
`default_nettype none
module tb;
    import emirq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] RD = 16'hC35A;
    logic        i_clk = 0, i_sys_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic        i_pause_load = 0, i_rx_overrun = 0, i_mdio_in, o_mdc, o_mdio_out, o_mdio_oe, o_irq;
    logic        o_pready, o_pslverr;
    logic [7:0]  i_paddr = '0;
    logic [15:0] i_pause_value = '0;
    logic [8:0]  ev = '0;
    logic [31:0] i_pwdata = '0, o_prdata, rdat, lf = 32'd303, w, rx;
    int          fails = 0, check_count = 0, st = 0, mk = 32'h3FFF, n, cyc = 0;
    int          bp[9] = '{1, 2, 3, 4, 5, 6, 7, 11, 12};
    always #5 i_clk = ~i_clk;
    emirq_regs #(.BIT_TIME_CYCLES(1)) u_emirq_regs (.i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite,
        .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_rx_done(ev[0]), .i_rx_used_desc(ev[1]),
        .i_tx_used_desc(ev[2]), .i_tx_underrun(ev[3]), .i_retry_limit(ev[4]), .i_tx_exhausted(ev[5]),
        .i_tx_frame_done(ev[6]), .i_rx_overrun, .i_bus_error(ev[7]), .i_pause_seen(ev[8]), .i_pause_load,
        .i_pause_value, .i_mdio_in, .o_mdc, .o_mdio_out, .o_mdio_oe, .o_irq);
    emirq_phy_model #(.RD(RD)) u_emirq_phy_model (.i_clk, .i_mdc(o_mdc), .i_mdio(o_mdio_out),
        .i_mdio_oe(o_mdio_oe), .o_mdio(i_mdio_in), .o_rx(rx));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    task automatic finish_test;
        if (fails == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    // Ready is waited for, never assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, wr, a, d};
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        rdat = o_prdata;
        chk("slverr", {31'h0, o_pslverr}, 0);
        {i_psel, i_penable} <= 2'b00;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        chk($sformatf("reg %h", a), rdat, e);
    endtask : rdc
    task automatic pulse(input logic [8:0] v);
        @(posedge i_clk);
        ev <= v;
        @(posedge i_clk);
        ev <= '0;
        for (int k = 0; k < 9; k++) if (v[k]) st |= 1 << bp[k];
    endtask : pulse
    task automatic irqc(input logic [31:0] e);
        repeat (2) @(posedge i_clk);
        #1 chk("irq", {31'h0, o_irq}, e);
    endtask : irqc
    always @(posedge i_clk) if (++cyc == 12000) begin
        fails++;
        finish_test();
    end
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rdc(OFS_IRQ_MASK, 32'h3FFF);
        for (int i = 0; i < 10; i++) begin
            lf = nx(lf);
            pulse(i < 9 ? 9'(1 << i) : lf[8:0]);
            rdc(OFS_IRQ_STATUS, st);
            rdc(OFS_IRQ_STATUS, 0);
            st = 0;
        end
        i_rx_overrun <= 1'b1;
        rdc(OFS_IRQ_STATUS, 32'h400);
        rdc(OFS_IRQ_STATUS, 0);
        for (int i = 0; i < 4; i++) begin
            lf = nx(lf);
            w = lf & 32'(IRQ_IMPL);
            apb(1'b1, i[0] ? OFS_IRQ_DISABLE : OFS_IRQ_ENABLE, w);
            mk = i[0] ? mk | w : mk & ~w;
            rdc(OFS_IRQ_MASK, mk);
        end
        apb(1'b1, OFS_IRQ_DISABLE, 32'h3FFF);
        apb(1'b1, 8'h00, 32'h3FFF);
        rdc(OFS_IRQ_MASK, 32'h3FFF);
        apb(1'b1, OFS_IRQ_ENABLE, 32'h80);
        pulse(9'h0C0);
        irqc(1);
        apb(1'b1, OFS_IRQ_DISABLE, 32'h80);
        irqc(0);
        apb(1'b1, OFS_IRQ_ENABLE, 32'h80);
        irqc(1);
        rdc(OFS_IRQ_STATUS, st);
        irqc(0);
        for (int i = 0; i < 3; i++) begin
            lf = nx(lf);
            w = {2'b01, i == 2 ? DIR_READ : DIR_WRITE, lf[9:0], 2'b10, lf[25:10]};
            apb(1'b1, OFS_PHY_FRAME, w);
            apb(1'b1, OFS_PHY_FRAME, ~w);
            n = 0;
            do apb(1'b0, OFS_IRQ_STATUS, '0); while (rdat !== 32'h1 && ++n < 300);
            chk("done", rdat, 1);
            chk("wire", rx, i == 2 ? 32'(w[31:18]) : w);
            rdc(OFS_PHY_FRAME, i == 2 ? {w[31:16], RD} : w);
        end
        {i_pause_load, i_pause_value} <= {1'b1, 16'h0001};
        @(posedge i_clk);
        i_pause_load <= 1'b0;
        repeat (1100) @(posedge i_clk);
        rdc(OFS_PAUSE, 0);
        rdc(OFS_IRQ_STATUS, 32'h2000);
        apb(1'b1, OFS_PAUSE, 32'h0002);
        rdc(OFS_PAUSE, 2);
        repeat (600) @(posedge i_clk);
        rdc(OFS_PAUSE, 1);
        rdc(OFS_IRQ_STATUS, 0);
        repeat (600) @(posedge i_clk);
        rdc(OFS_PAUSE, 0);
        rdc(OFS_IRQ_STATUS, 32'h2000);
        finish_test();
    end
endmodule : tb
`default_nettype wire
